/* rtc_watchdog_interrupt_logic.sv */
// Watchdog down counter, interrupt flags/enables and interrupt pin driver
//
// How it works
// - Watchdog counts down once per 32 Hz tick, only while oscillator runs.
// - At reset the counter loads the zero reset timeout, so the watchdog stays off.
// - Writing kick bit one reloads counter; early kicks raise nothing.
// - Counter hitting zero sets timeout flag; interrupt if enabled.
// - Timeout value bits are written only when the same write has lock bit zero.
// - Timeout value of zero disables the watchdog entirely.
// - With timeout enable clear, a timeout only sets its flag.
// - Alarm match sets alarm flag; drives interrupt when alarm enabled.
// - Power fail sets its flag; drives interrupt when enabled.
// - Interrupt is the OR of flags ANDed with their enables.
// - Enables live in interrupt control, flags in event flags register.
// - Polarity bit picks active-high push-pull or active-low open-drain.
// - Pulse bit gives a 200 ms pulse, else level until flags read.
// - Flags read clears the flags it returned, except the oscillator-fail bit, and ends the output, pulse too.
// - Each flag is set by its own source; host polls or uses interrupt.
// - After reset flags are zero except the oscillator-fail bit.
// - No interrupts while running from backup power.
// - On backup power, register access by the user is blocked.
// - Alarm flag is set whenever the alarm comparison reports a match.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rtc_watchdog_interrupt_logic
   import wdt_irq_pkg::*;
#(
   parameter int tick_cycles  = wd_tick_cycles,
   parameter int pulse_length = pulse_cycles
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [17:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        osc_running,
   input  wire logic        osc_fail_in,
   input  wire logic        alarm_match,
   input  wire logic        supply_low,
   input  wire logic        on_backup,
   output logic             int_out,
   output logic             int_oe_n
);
   bus_state_t  state;
   logic [7:0]  event_flags;
   logic [7:0]  interrupt_control;
   logic [7:0]  watchdog_control;
   logic [5:0]  wd_count;
   logic [31:0] tick_div;
   logic [31:0] pulse_count;
   logic        tick;
   logic        wd_expire;
   logic        supply_low_d;
   logic        power_fail_evt;
   logic        irq_active;
   logic        pulse_busy;
   logic        level_busy;
   logic        flags_read;
   logic        reg_write;
   logic        lane0;
   logic [15:0] reg_idx;
   logic [7:0]  wdata;
   logic [7:0]  next_read;
   source_set_t pend;

   assign reg_idx = avs_address[17:2];
   assign wdata   = avs_writedata[7:0];
   assign lane0   = avs_byteenable[0];

   // Two-cycle access: request seen in idle, answered from bus_hold
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= bus_idle;
      end else begin
         case (state)
            bus_idle: if (avs_read || avs_write) state <= bus_hold;
            bus_hold: state <= bus_done;
            bus_done: state <= bus_idle;
            default:  state <= bus_idle;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !(state == bus_idle && (avs_read || avs_write));
      end
   end

   // Blocked accesses still complete, writes dropped, reads give zero
   assign reg_write  = state == bus_hold && avs_write && lane0 &&
                       !on_backup;
   assign flags_read = state == bus_hold && avs_read && !on_backup &&
                       reg_idx == event_flags_idx;

   always_comb begin
      next_read = 8'h00;
      if (!on_backup) begin
         case (reg_idx)
            event_flags_idx:       next_read = event_flags;
            interrupt_control_idx: next_read = interrupt_control;
            watchdog_control_idx:  next_read = {2'b00, watchdog_control[5:0]};
            supply_status_idx:     next_read = {7'h00, irq_active};
            default:               next_read = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (state == bus_idle && avs_read) begin
         avs_readdata <= {24'h000000, next_read};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         interrupt_control <= interrupt_control_reset;
      end else if (reg_write && reg_idx == interrupt_control_idx) begin
         interrupt_control <= wdata & interrupt_control_mask;
      end
   end

   // Lock bit written in the same access governs the timeout field
   always_ff @(posedge clk) begin
      if (rst) begin
         watchdog_control <= watchdog_control_reset;
      end else if (reg_write && reg_idx == watchdog_control_idx) begin
         watchdog_control[wd_lock_bit] <= wdata[wd_lock_bit];
         if (!wdata[wd_lock_bit]) begin
            watchdog_control[5:0] <= wdata[5:0];
         end
      end
   end

   // 32 Hz tick from the oscillator, frozen while it is stopped
   always_ff @(posedge clk) begin
      if (rst) begin
         tick_div <= 32'h0000_0000;
      end else if (osc_running) begin
         if (tick_div >= 32'(tick_cycles - 1)) begin
            tick_div <= 32'h0000_0000;
         end else begin
            tick_div <= tick_div + 32'h0000_0001;
         end
      end
   end
   assign tick = osc_running && tick_div >= 32'(tick_cycles - 1);

   wire kick = reg_write && reg_idx == watchdog_control_idx &&
               wdata[wd_kick_bit];
   assign wd_expire = tick && wd_count == 6'h01 &&
                      watchdog_control[5:0] != timeout_zero;

   // Reload on expiry keeps the watchdog free running
   always_ff @(posedge clk) begin
      if (rst) begin
         wd_count <= watchdog_control_reset[5:0];
      end else if (kick) begin
         wd_count <= watchdog_control[5:0];
      end else if (tick) begin
         if (wd_count <= 6'h01) begin
            wd_count <= watchdog_control[5:0];
         end else begin
            wd_count <= wd_count - 6'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         supply_low_d <= 1'b0;
      end else begin
         supply_low_d <= supply_low;
      end
   end
   assign power_fail_evt = supply_low && !supply_low_d &&
                           !on_backup;

   // Set wins over the read clear; only bits the read returned are cleared,
   // so an event after the data was captured survives for the next read
   always_ff @(posedge clk) begin
      // Oscillator-fail bit follows its own detector, not the reset
      event_flags[flag_osc_bit] <= osc_fail_in;
      event_flags[3:0] <= event_flags_reset[3:0];
      if (rst) begin
         event_flags[7:5] <= event_flags_reset[7:5];
      end else begin
         if (flags_read) begin
            event_flags[7:5] <= event_flags[7:5] &
                                ~avs_readdata[7:5];
         end
         if (wd_expire) event_flags[flag_timeout_bit] <= 1'b1;
         if (alarm_match) event_flags[flag_alarm_bit] <= 1'b1;
         if (power_fail_evt) begin
            event_flags[flag_power_bit] <= 1'b1;
         end
      end
   end

   assign pend = flags_of(event_flags) & enables_of(interrupt_control);
   wire any_pend = (|pend) && !on_backup;
   wire new_pend = (wd_expire && interrupt_control[ctl_timeout_en_bit]) ||
                   (alarm_match && interrupt_control[ctl_alarm_en_bit]) ||
                   (power_fail_evt && interrupt_control[ctl_power_en_bit]);

   // Pulse mode: fixed width, cut short by a flags read
   always_ff @(posedge clk) begin
      if (rst) begin
         pulse_count <= 32'h0000_0000;
      end else if (on_backup) begin
         pulse_count <= 32'h0000_0000;
      end else if (new_pend && (!pulse_busy || flags_read)) begin
         pulse_count <= 32'(pulse_length);
      end else if (flags_read) begin
         pulse_count <= 32'h0000_0000;
      end else if (pulse_count != 32'h0000_0000) begin
         pulse_count <= pulse_count - 32'h0000_0001;
      end
   end
   assign pulse_busy = pulse_count != 32'h0000_0000;
   assign level_busy = any_pend && !flags_read;

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_active <= 1'b0;
      end else if (interrupt_control[ctl_pulse_bit]) begin
         irq_active <= pulse_busy && !flags_read && !on_backup;
      end else begin
         irq_active <= level_busy;
      end
   end

   // Active-high drives both levels; active-low only pulls down
   always_ff @(posedge clk) begin
      if (rst) begin
         int_out  <= 1'b0;
         int_oe_n <= 1'b1;
      end else if (interrupt_control[ctl_high_bit]) begin
         int_out  <= irq_active && !on_backup;
         int_oe_n <= 1'b0;
      end else begin
         int_out  <= 1'b0;
         int_oe_n <= !(irq_active && !on_backup);
      end
   end
endmodule
`default_nettype wire

/* wdt_irq_pkg.sv */
// Package: register map, field layout and timing constants of the watchdog and interrupt block
package wdt_irq_pkg;
   // Offsets are register indices, so byte address = 4 * index
   localparam logic [15:0] event_flags_idx       = 16'h7FF0;
   localparam logic [15:0] interrupt_control_idx = 16'h7FF6;
   localparam logic [15:0] watchdog_control_idx  = 16'h7FF7;
   localparam logic [15:0] supply_status_idx     = 16'h7FE0;

   // Flag bit positions
   localparam int flag_timeout_bit = 7;
   localparam int flag_alarm_bit   = 6;
   localparam int flag_power_bit   = 5;
   localparam int flag_osc_bit     = 4;
   // Interrupt control bit positions
   localparam int ctl_timeout_en_bit = 7;
   localparam int ctl_alarm_en_bit   = 6;
   localparam int ctl_power_en_bit   = 5;
   localparam int ctl_high_bit       = 3;
   localparam int ctl_pulse_bit      = 2;
   // Watchdog control bit positions
   localparam int wd_kick_bit = 7;
   localparam int wd_lock_bit = 6;

   localparam logic [7:0] event_flags_reset       = 8'h00;
   localparam logic [7:0] interrupt_control_reset = 8'h08;
   localparam logic [7:0] watchdog_control_reset  = 8'h00;
   localparam logic [7:0] interrupt_control_mask  = 8'hEC;
   localparam logic [5:0] timeout_zero            = 6'h00;

   // Timing
   localparam int clk_hz            = 200_000_000;
   localparam int wd_tick_hz        = 32;
   localparam int pulse_ms          = 200;
   localparam int wd_tick_cycles    = clk_hz / wd_tick_hz;
   localparam int pulse_cycles      = (clk_hz / 1000) * pulse_ms;

   typedef enum logic [1:0] {
      bus_idle  = 2'b00,
      bus_hold  = 2'b01,
      bus_done  = 2'b11
   } bus_state_t;

   typedef struct packed {
      logic timeout;
      logic alarm;
      logic power;
   } source_set_t;

   function automatic source_set_t flags_of(input logic [7:0] f);
      flags_of.timeout = f[flag_timeout_bit];
      flags_of.alarm   = f[flag_alarm_bit];
      flags_of.power   = f[flag_power_bit];
   endfunction

   function automatic source_set_t enables_of(input logic [7:0] c);
      enables_of.timeout = c[ctl_timeout_en_bit];
      enables_of.alarm   = c[ctl_alarm_en_bit];
      enables_of.power   = c[ctl_power_en_bit];
   endfunction
endpackage

/* wdt_irq_properties.sv */
// Checker of bus answer timing and interrupt pin behaviour
`timescale 1ns/10ps
`default_nettype none
module wdt_irq_checker
   import wdt_irq_pkg::*;
#(
   parameter int tick_cycles  = wd_tick_cycles,
   parameter int pulse_length = pulse_cycles
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [17:0] avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        alarm_match,
   input wire logic        supply_low,
   input wire logic        on_backup,
   input wire logic        int_out,
   input wire logic        int_oe_n
);
   logic [7:0] ctl;
   logic       act;
   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);
   // Shadow of the control byte, so pin checks know the output style
   always_ff @(posedge clk) begin
      if (rst)
         ctl <= interrupt_control_reset;
      else if (avs_write && !avs_waitrequest && !on_backup
               && avs_byteenable[0]
               && avs_address[17:2] == interrupt_control_idx)
         ctl <= avs_writedata[7:0] & interrupt_control_mask;
   end
   assign act = ctl[ctl_high_bit] ? int_out : !int_oe_n;
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_bus_answer: assert property ((avs_read || avs_write) &&
      avs_waitrequest |=> s_answer) else $error("bus answer late");
   a_backup_read_zero: assert property (
      on_backup && $past(on_backup) && avs_read && !avs_waitrequest
      |-> avs_readdata == 32'h0) else $error("read data on backup power");
   a_backup_quiet: assert property (on_backup [*2] |-> !act)
      else $error("interrupt on backup power");
   a_high_drives: assert property (
      ctl[ctl_high_bit] [*3] |-> !int_oe_n)
      else $error("push-pull pin not driven");
   a_low_no_data: assert property (
      !ctl[ctl_high_bit] [*2] |-> !int_out)
      else $error("open-drain pin drives high");
   a_enable_needed: assert property (
      (ctl[7:5] == 3'h0) [*3] |-> !act)
      else $error("interrupt without enable");
   a_alarm_raise: assert property (
      ctl[ctl_alarm_en_bit] && alarm_match && !on_backup |-> ##[1:3] act)
      else $error("alarm interrupt missing");
   a_power_raise: assert property (
      ctl[ctl_power_en_bit] && $rose(supply_low) && !on_backup
      |-> ##[1:3] act) else $error("power interrupt missing");
endmodule
bind rtc_watchdog_interrupt_logic wdt_irq_checker #(
   .tick_cycles(tick_cycles), .pulse_length(pulse_length)) wdt_irq_checker_i (
   .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .alarm_match(alarm_match), .supply_low(supply_low), .on_backup(on_backup),
   .int_out(int_out), .int_oe_n(int_oe_n));
`default_nettype wire

/* host_int_model.sv */
// Host end of the interrupt pin: pull-up and active-level decode
`timescale 1ns/10ps
`default_nettype none
module host_int_model (
   input  wire logic int_out,
   input  wire logic int_oe_n,
   input  wire logic active_high,
   output logic      pin,
   output logic      irq_seen
);
   // Released open-drain pin rests at the pull-up level
   assign pin = int_oe_n ? 1'b1 : int_out;
   assign irq_seen = (pin == active_high);
endmodule
`default_nettype wire

/* tb_top.sv */
// Bench: register accesses, watchdog, alarm, power fail and backup cases
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import wdt_irq_pkg::*;
   localparam int          pl    = 20;
   localparam logic [15:0] flags = event_flags_idx;
   localparam logic [15:0] ctl   = interrupt_control_idx;
   localparam logic [15:0] wdog  = watchdog_control_idx;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [17:0] avs_address = 18'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic        osc_running = 1'b1;
   logic        alarm_match = 1'b0;
   logic        supply_low = 1'b0;
   logic        on_backup = 1'b0;
   logic        active_high = 1'b1;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        int_out;
   logic        int_oe_n;
   logic        pin;
   logic        irq_seen;
   int          fails = 0;
   int          cmp_count = 0;
   int          n;
   rtc_watchdog_interrupt_logic #(.tick_cycles(8), .pulse_length(pl))
      rtc_watchdog_interrupt_logic_i (.clk(clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .osc_running(osc_running), .osc_fail_in(1'b1),
      .alarm_match(alarm_match), .supply_low(supply_low),
      .on_backup(on_backup), .int_out(int_out), .int_oe_n(int_oe_n));
   host_int_model host_int_model_i (.int_out(int_out), .int_oe_n(int_oe_n),
      .active_high(active_high), .pin(pin), .irq_seen(irq_seen));
   initial forever #2.5 clk = ~clk;
   task automatic results();
      if (fails == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Reads compare against v; writes send v
   task automatic acc(input logic we, input logic [15:0] idx,
                      input logic [7:0] v);
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, v};
      avs_read <= !we;
      avs_write <= we;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) begin
         fails++;
         results();
      end
      if (!we)
         chk(avs_readdata[7:0], v);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wait_seen();
      for (n = 0; n < 100 && irq_seen !== 1'b1; n++)
         @(posedge clk);
      if (n >= 100) begin
         fails++;
         results();
      end
   endtask
   task automatic alarm();
      @(posedge clk);
      alarm_match <= 1'b1;
      @(posedge clk);
      alarm_match <= 1'b0;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      acc(1'b0, flags, 8'h10);
      acc(1'b0, ctl, 8'h08);
      acc(1'b0, 16'h7FF5, 8'h00);
      repeat (40) @(posedge clk);
      acc(1'b0, flags, 8'h10);
      acc(1'b1, wdog, 8'h03);
      acc(1'b1, wdog, 8'h45);
      acc(1'b0, wdog, 8'h03);
      repeat (4) begin
         acc(1'b1, wdog, 8'hC0);
         repeat (8) @(posedge clk);
      end
      acc(1'b0, flags, 8'h10);
      osc_running <= 1'b0;
      repeat (60) @(posedge clk);
      acc(1'b0, flags, 8'h10);
      osc_running <= 1'b1;
      repeat (40) @(posedge clk);
      acc(1'b1, wdog, 8'h00);
      chk({7'h0, irq_seen}, 8'h00);
      acc(1'b0, flags, 8'h90);
      acc(1'b0, flags, 8'h10);
      acc(1'b1, ctl, 8'h88);
      acc(1'b1, wdog, 8'h02);
      acc(1'b1, wdog, 8'hC0);
      wait_seen();
      acc(1'b1, wdog, 8'h00);
      chk({7'h0, irq_seen}, 8'h01);
      acc(1'b0, flags, 8'h90);
      repeat (3) @(posedge clk);
      chk({7'h0, irq_seen}, 8'h00);
      active_high <= 1'b0;
      acc(1'b1, ctl, 8'h44);
      repeat (2) @(posedge clk);
      chk({7'h0, pin}, 8'h01);
      alarm();
      wait_seen();
      // Pin used as a host reset: no flags read while it stands
      for (n = 0; n < 100 && irq_seen === 1'b1; n++)
         @(posedge clk);
      chk(8'(n), 8'(pl));
      acc(1'b0, flags, 8'h50);
      alarm();
      wait_seen();
      acc(1'b0, flags, 8'h50);
      repeat (3) @(posedge clk);
      chk({7'h0, irq_seen}, 8'h00);
      acc(1'b1, ctl, 8'h08);
      active_high <= 1'b1;
      alarm();
      repeat (5) @(posedge clk);
      chk({7'h0, irq_seen}, 8'h00);
      acc(1'b0, flags, 8'h50);
      acc(1'b1, ctl, 8'h28);
      supply_low <= 1'b1;
      wait_seen();
      acc(1'b0, flags, 8'h30);
      supply_low <= 1'b0;
      acc(1'b1, ctl, 8'h48);
      on_backup <= 1'b1;
      alarm();
      repeat (5) @(posedge clk);
      chk({7'h0, irq_seen}, 8'h00);
      acc(1'b1, ctl, 8'hE8);
      acc(1'b0, ctl, 8'h00);
      on_backup <= 1'b0;
      acc(1'b0, ctl, 8'h48);
      // Alarm held across a flags read must survive into the next read
      alarm_match <= 1'b1;
      acc(1'b0, flags, 8'h50);
      alarm_match <= 1'b0;
      acc(1'b0, flags, 8'h50);
      acc(1'b0, flags, 8'h10);
      results();
   end
endmodule
`default_nettype wire
